/* pkg/phy_tune_pkg.sv */
/*
 * Constants, field layout and carrier types for the lane tuning bank.
 * Assumes a single 100 MHz core clock and dword writes from the
 * EEPROM preload engine and the SMBus/I2C slave.
 */
// Overview of operation
// RL1 - rx detect wait code bits 6:4
// RL2 - sample lane threshold after wait ends
// RL3 - signal detect class bits 21:20 per port
// RL4 - receiver equalization bits 25:22 per port
// RL5 - bit 30 selects full or half swing
// RL6 - de-emphasis only active at full swing
// RL7 - full swing de-emphasis plus per-channel offset
// RL8 - every channel tuned on its own
// RL9 - exactly one of three amplitude base fields
// RL10 - amplitude codes above 10011 are reserved
// RL11 - software keeps amplitude plus de-emphasis bounded
// RL12 - de-emphasis base fields in first register
// RL13 - de-emphasis base code is five bits
// RL14 - final level is base plus offset
// RL15 - electrical idle latency bits 3:0
// RL16 - preload, later overwrites, continuous drive
package phy_tune_pkg;
	// ----------------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_OPMODE = 8'h74;
	localparam logic [7:0] OFS_PHY1 = 8'h78;
	localparam logic [7:0] OFS_PHY2 = 8'h7C;
	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int AMP_FULL_MILD_LSB = 16;
	localparam int AMP_FULL_STRONG_LSB = 21;
	localparam int AMP_HALF_LSB = 26;
	localparam int DE_G1_MILD_LSB = 16;
	localparam int DE_G2_MILD_LSB = 21;
	localparam int DE_G2_STRONG_LSB = 26;
	localparam int TXLAT_LSB = 0;
	localparam int RXDET_LSB = 4;
	localparam int SIGDET_LSB = 20;
	localparam int EQ_LSB = 22;
	localparam int SWING_BIT = 30;
	// ----------------------------------------------------------------
	// reset values: recommended classes, mid amplitudes
	// ----------------------------------------------------------------
	localparam logic [31:0] RST_OPMODE = 32'h2210_0000;
	localparam logic [31:0] RST_PHY1 = 32'h2108_0000;
	localparam logic [31:0] RST_PHY2 = 32'h0190_0024;
	localparam logic [5:0] AMP_MAX_CODE = 6'h13;
	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int CYC_PER_US = 1000 / CLK_PERIOD_NS;
	localparam logic [5:0] RXDET_US [8] = '{6'h01, 6'h02, 6'h04, 6'h05,
		6'h0A, 6'h14, 6'h28, 6'h32};
	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic en;
		logic [3:0] port;
		logic [7:0] addr;
		logic [31:0] data;
	} cfg_wr_s;
	typedef struct packed {
		logic halfSwing;
		logic [5:0] ampCode;
		logic ampReserved;
		logic [5:0] deemphCode;
		logic [3:0] eqCode;
		logic [1:0] sigDetCode;
	} lane_ctrl_s;
	typedef enum logic {RD_IDLE, RD_WAIT} rxdet_state_e;
endpackage : phy_tune_pkg

/* hdl/phy_lane_tuning_control.sv */
/*
 * Per-port tuning registers and per-lane decode for the serdes front end,
 * with receiver-detect timing and transmit electrical-idle latency.
 * Assumes the preload engine and SMBus/I2C slave deliver whole dwords,
 * and that lane analog status inputs are synchronous to clk_sys.
 */
`timescale 1ns/1ns
module phy_lane_tuning_control
	import phy_tune_pkg::*;
#(
	parameter int NUM_PORTS = 3,
	parameter int LANES_PER_PORT = 4,
	parameter int CYCLES_PER_US = CYC_PER_US
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic ce,
	input wire cfg_wr_s preloadWr,
	input wire cfg_wr_s smbusWr,
	input wire logic [3:0] smbusRdPort,
	input wire logic [7:0] smbusRdAddr,
	output logic [31:0] smbusRdData,
	input wire logic [NUM_PORTS-1:0] gen2Rate,
	input wire logic [NUM_PORTS-1:0] strongDeemph,
	input wire logic [NUM_PORTS*LANES_PER_PORT-1:0][4:0] ampOffset,
	input wire logic [NUM_PORTS*LANES_PER_PORT-1:0][4:0] deemphOffset,
	input wire logic [NUM_PORTS*LANES_PER_PORT-1:0] rxDetStart,
	input wire logic [NUM_PORTS*LANES_PER_PORT-1:0] laneAboveThr,
	input wire logic [NUM_PORTS*LANES_PER_PORT-1:0] txActive,
	output lane_ctrl_s [NUM_PORTS*LANES_PER_PORT-1:0] laneCtrl,
	output logic [NUM_PORTS*LANES_PER_PORT-1:0] rxPresent,
	output logic [NUM_PORTS*LANES_PER_PORT-1:0] rxDetDone,
	output logic [NUM_PORTS*LANES_PER_PORT-1:0] txElecIdle
);
	localparam int NUM_LANES = NUM_PORTS * LANES_PER_PORT;

	// port index is four bits; wait counter is twenty bits
	if (NUM_PORTS < 1 || NUM_PORTS > 16 || LANES_PER_PORT < 1 ||
		CYCLES_PER_US < 1 || CYCLES_PER_US * 50 >= (1 << 20)) begin : g_chk
		$error("phy_lane_tuning_control: unsupported parameters");
	end

	// ----------------------------------------------------------------
	// register bank
	// ----------------------------------------------------------------
	logic [NUM_PORTS-1:0][31:0] opMode_reg, opMode_next;
	logic [NUM_PORTS-1:0][31:0] phy1_reg, phy1_next;
	logic [NUM_PORTS-1:0][31:0] phy2_reg, phy2_next;
	logic [31:0] rdData_next;
	cfg_wr_s wr;

	// RL16 preload and later overwrites
	// preload wins a same-cycle clash: it only runs right after reset
	always_comb begin
		wr = preloadWr.en ? preloadWr : smbusWr;
		opMode_next = opMode_reg;
		phy1_next = phy1_reg;
		phy2_next = phy2_reg;
		rdData_next = 32'h0000_0000;
		for (int p = 0; p < NUM_PORTS; p++) begin
			if (wr.en && wr.port == 4'(p)) begin
				unique case (wr.addr)
					OFS_OPMODE: opMode_next[p] = wr.data;
					OFS_PHY1: phy1_next[p] = wr.data;
					OFS_PHY2: phy2_next[p] = wr.data;
					default: ;
				endcase
			end
			if (smbusRdPort == 4'(p)) begin
				unique case (smbusRdAddr)
					OFS_OPMODE: rdData_next = opMode_reg[p];
					OFS_PHY1: rdData_next = phy1_reg[p];
					OFS_PHY2: rdData_next = phy2_reg[p];
					default: rdData_next = 32'h0000_0000;
				endcase
			end
		end
	end

	// register update; ce low freezes everything
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			opMode_reg <= {NUM_PORTS{RST_OPMODE}};
			phy1_reg <= {NUM_PORTS{RST_PHY1}};
			phy2_reg <= {NUM_PORTS{RST_PHY2}};
			smbusRdData <= 32'h0000_0000;
		end else if (ce) begin
			opMode_reg <= opMode_next;
			phy1_reg <= phy1_next;
			phy2_reg <= phy2_next;
			smbusRdData <= rdData_next;
		end
	end

	// ----------------------------------------------------------------
	// per-lane decode, receiver detect and idle latency
	// ----------------------------------------------------------------
	for (genvar l = 0; l < NUM_LANES; l++) begin : g_lane
		localparam int P = l / LANES_PER_PORT;
		lane_ctrl_s ctrl_next;
		rxdet_state_e rdState_reg, rdState_next;
		logic [19:0] rdCnt_reg, rdCnt_next;
		logic present_next, done_next;
		logic [3:0] idleCnt_reg, idleCnt_next;
		logic idle_next;
		logic [4:0] ampBase, deBase;
		logic [2:0] rdCode;

		// RL8 per-channel decode of shared port fields
		always_comb begin
			// RL5 swing select
			ctrl_next.halfSwing = phy2_reg[P][SWING_BIT];
			// RL9 exactly one amplitude base field
			if (phy2_reg[P][SWING_BIT])
				ampBase = opMode_reg[P][AMP_HALF_LSB +: 5];
			else if (gen2Rate[P] && strongDeemph[P])
				ampBase = opMode_reg[P][AMP_FULL_STRONG_LSB +: 5];
			else
				ampBase = opMode_reg[P][AMP_FULL_MILD_LSB +: 5];
			// RL12 de-emphasis base by rate and condition
			if (!gen2Rate[P])
				deBase = phy1_reg[P][DE_G1_MILD_LSB +: 5];
			else if (strongDeemph[P])
				deBase = phy1_reg[P][DE_G2_STRONG_LSB +: 5];
			else
				deBase = phy1_reg[P][DE_G2_MILD_LSB +: 5];
			// RL14 base plus offset, one extra bit of headroom
			ctrl_next.ampCode = {1'b0, ampBase} + {1'b0, ampOffset[l]};
			// RL10 codes above the top step are reserved
			ctrl_next.ampReserved = ctrl_next.ampCode > AMP_MAX_CODE;
			// RL6 RL7 RL13 de-emphasis only at full swing
			ctrl_next.deemphCode = phy2_reg[P][SWING_BIT] ? 6'h00 :
				{1'b0, deBase} + {1'b0, deemphOffset[l]};
			// RL4 equalization passed through
			ctrl_next.eqCode = phy2_reg[P][EQ_LSB +: 4];
			// RL3 signal detect class
			ctrl_next.sigDetCode = phy2_reg[P][SIGDET_LSB +: 2];

			// RL1 wait time from the three-bit code
			rdCode = phy2_reg[P][RXDET_LSB +: 3];
			rdState_next = rdState_reg;
			rdCnt_next = rdCnt_reg;
			present_next = rxPresent[l];
			done_next = 1'b0;
			unique case (rdState_reg)
				RD_IDLE: begin
					if (rxDetStart[l]) begin
						rdState_next = RD_WAIT;
						rdCnt_next = 20'(int'(RXDET_US[rdCode]) * CYCLES_PER_US - 1);
					end
				end
				RD_WAIT: begin
					if (rdCnt_reg == 20'h00000) begin
						// RL2 sample the threshold once the wait ends
						rdState_next = RD_IDLE;
						present_next = laneAboveThr[l];
						done_next = 1'b1;
					end else begin
						rdCnt_next = rdCnt_reg - 20'h00001;
					end
				end
			endcase

			// RL15 idle after latency count past last character
			idleCnt_next = idleCnt_reg;
			idle_next = txElecIdle[l];
			if (txActive[l]) begin
				idleCnt_next = phy2_reg[P][TXLAT_LSB +: 4];
				idle_next = 1'b0;
			end else if (idleCnt_reg == 4'h0) begin
				idle_next = 1'b1;
			end else begin
				idleCnt_next = idleCnt_reg - 4'h1;
			end
		end

		// RL16 lane outputs driven continuously from flops
		always_ff @(posedge clk_sys) begin
			if (rst) begin
				laneCtrl[l] <= '0;
				rdState_reg <= RD_IDLE;
				rdCnt_reg <= 20'h00000;
				rxPresent[l] <= 1'b0;
				rxDetDone[l] <= 1'b0;
				idleCnt_reg <= 4'h0;
				txElecIdle[l] <= 1'b1;
			end else if (ce) begin
				laneCtrl[l] <= ctrl_next;
				rdState_reg <= rdState_next;
				rdCnt_reg <= rdCnt_next;
				rxPresent[l] <= present_next;
				rxDetDone[l] <= done_next;
				idleCnt_reg <= idleCnt_next;
				txElecIdle[l] <= idle_next;
			end
		end
	end

	// ----------------------------------------------------------------
	// checks on lane 0 and port 0, plus unmapped reads on any port
	// ----------------------------------------------------------------
	// lane 0 wait length, counted apart from the detect counter
	logic [19:0] waitSeen_reg, waitSeen_next;

	always_comb begin
		waitSeen_next = (g_lane[0].rdState_reg == RD_IDLE) ? 20'h00000 :
			waitSeen_reg + 20'h00001;
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			waitSeen_reg <= 20'h00000;
		end else if (ce) begin
			waitSeen_reg <= waitSeen_next;
		end
	end

	a_half_no_deemph: assert property (@(posedge clk_sys) // RL6
		disable iff (rst || !ce) laneCtrl[0].halfSwing |->
		laneCtrl[0].deemphCode == 6'h00)
		else $error("de-emphasis active at half swing");
	a_amp_reserved: assert property (@(posedge clk_sys) // RL10
		disable iff (rst || !ce)
		laneCtrl[0].ampReserved == (laneCtrl[0].ampCode > AMP_MAX_CODE))
		else $error("amplitude reserved flag wrong");
	a_write_lands: assert property (@(posedge clk_sys) // RL16
		disable iff (rst || !ce) (preloadWr.en && preloadWr.port == 4'h0 &&
		preloadWr.addr == OFS_PHY2) |=> ##1
		laneCtrl[0].eqCode == $past(preloadWr.data[EQ_LSB +: 4], 2))
		else $error("preload write did not reach lane");
	a_rxdet_sample: assert property (@(posedge clk_sys) // RL2
		disable iff (rst || !ce) rxDetDone[0] |->
		rxPresent[0] == $past(laneAboveThr[0]) && !$past(rxDetDone[0]))
		else $error("receiver detect sampled wrongly");
	a_rxdet_wait: assert property (@(posedge clk_sys) // RL1
		disable iff (rst || !ce) rxDetDone[0] |->
		waitSeen_reg == 20'(int'(RXDET_US[phy2_reg[0][RXDET_LSB +: 3]]) *
		CYCLES_PER_US))
		else $error("receiver detect wait length wrong");
	a_eidle_clear: assert property (@(posedge clk_sys) // RL15
		disable iff (rst || !ce) txActive[0] |=> !txElecIdle[0])
		else $error("idle while transmitting");
	a_eidle_lat0: assert property (@(posedge clk_sys) // RL15
		disable iff (rst || !ce) (txActive[0] &&
		phy2_reg[0][TXLAT_LSB +: 4] == 4'h0 ##1 !txActive[0]) |=>
		txElecIdle[0])
		else $error("idle latency zero not honoured");
	a_rd_unmapped: assert property (@(posedge clk_sys) // RL16
		disable iff (rst || !ce) (smbusRdAddr != OFS_OPMODE &&
		smbusRdAddr != OFS_PHY1 && smbusRdAddr != OFS_PHY2) |=>
		smbusRdData == 32'h0000_0000)
		else $error("unmapped read not zero");
endmodule : phy_lane_tuning_control

/* verif/lane_analog_model.sv */
/*
 * Far-end lane analog model: the detect comparator of each lane.
 * Assumes the bench sets farTerm per lane to place a termination.
 */
`timescale 1ns/1ns
module lane_analog_model #(
	parameter int LANES = 4
) (
	input wire logic clk_sys,
	input wire logic [LANES-1:0] farTerm,
	output logic [LANES-1:0] laneAboveThr
);
	// termination crosses threshold
	// one clock of settling, so a fresh load is never seen at once
	always_ff @(posedge clk_sys) begin
		laneAboveThr <= farTerm;
	end
endmodule : lane_analog_model

/* verif/test_phy_lane_tuning_control.sv */
/*
 * Self-checking bench for the lane tuning bank.
 * Assumes the design package and the lane analog model.
 */
`timescale 1ns/1ns
module test_phy_lane_tuning_control;
	import phy_tune_pkg::*;
	localparam int NP = 2;
	localparam int LP = 2;
	localparam int NL = NP * LP;
	localparam int CPU = 2;
	logic clk_sys = 0;
	logic rst = 1;
	logic ce = 1;
	cfg_wr_s preloadWr = '0;
	cfg_wr_s smbusWr = '0;
	logic [3:0] smbusRdPort = '0;
	logic [7:0] smbusRdAddr = '0;
	logic [31:0] smbusRdData;
	logic [NP-1:0] gen2Rate = '0;
	logic [NP-1:0] strongDeemph = '0;
	logic [NL-1:0][4:0] ampOffset = '0;
	logic [NL-1:0][4:0] deemphOffset = '0;
	logic [NL-1:0] rxDetStart = '0;
	logic [NL-1:0] laneAboveThr;
	logic [NL-1:0] farTerm = '0;
	logic [NL-1:0] txActive = '0;
	lane_ctrl_s [NL-1:0] laneCtrl;
	logic [NL-1:0] rxPresent;
	logic [NL-1:0] rxDetDone;
	logic [NL-1:0] txElecIdle;
	logic [31:0] opm [NP];
	logic [31:0] ph1 [NP];
	logic [31:0] ph2 [NP];
	logic [3:0] lat;
	int seed = 32'hD4840DD1;
	int mismatches = 0;
	int nChecks = 0;
	int n;

	phy_lane_tuning_control #(.NUM_PORTS(NP), .LANES_PER_PORT(LP),
		.CYCLES_PER_US(CPU)) phy_lane_tuning_control_i (.clk_sys, .rst,
		.ce, .preloadWr, .smbusWr, .smbusRdPort, .smbusRdAddr,
		.smbusRdData, .gen2Rate, .strongDeemph, .ampOffset, .deemphOffset,
		.rxDetStart, .laneAboveThr, .txActive, .laneCtrl, .rxPresent,
		.rxDetDone, .txElecIdle);
	lane_analog_model #(.LANES(NL)) lane_analog_model_i (.clk_sys,
		.farTerm, .laneAboveThr);

	// ----------------------------------------------------------------
	// clock, checking and bus tasks
	// ----------------------------------------------------------------
	always #5 clk_sys = ~clk_sys;

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		nChecks++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
		end
	endtask : chk

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", nChecks, mismatches);
		if (mismatches == 0 && nChecks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : tally_and_finish

	// shadow copy kept so expectations never come from the design
	task automatic wr(input int p, input logic [7:0] a, input logic [31:0] d);
		@(negedge clk_sys);
		smbusWr <= '{1'b1, 4'(p), a, d};
		@(negedge clk_sys);
		smbusWr.en <= 1'b0;
		if (a == OFS_OPMODE) opm[p] = d;
		if (a == OFS_PHY1) ph1[p] = d;
		if (a == OFS_PHY2) ph2[p] = d;
	endtask : wr

	task automatic rd(input int p, input logic [7:0] a, input logic [31:0] e);
		@(negedge clk_sys);
		smbusRdPort <= 4'(p);
		smbusRdAddr <= a;
		@(negedge clk_sys);
		chk(smbusRdData, e);
	endtask : rd

	task automatic rd_all();
		for (int p = 0; p < NP; p++) begin
			rd(p, OFS_OPMODE, opm[p]);
			rd(p, OFS_PHY1, ph1[p]);
			rd(p, OFS_PHY2, ph2[p]);
		end
		rd(0, 8'h70, 32'h0);
		rd(3, OFS_PHY1, 32'h0);
	endtask : rd_all

	// decode worked out from the field layout
	function automatic lane_ctrl_s exp_ctrl(input int l);
		int p;
		lane_ctrl_s c;
		logic [4:0] ab;
		logic [4:0] db;
		p = l / LP;
		c.halfSwing = ph2[p][30];
		ab = c.halfSwing ? opm[p][30:26] :
			(gen2Rate[p] && strongDeemph[p]) ? opm[p][25:21] : opm[p][20:16];
		db = !gen2Rate[p] ? ph1[p][20:16] :
			strongDeemph[p] ? ph1[p][30:26] : ph1[p][25:21];
		c.ampCode = ab + ampOffset[l];
		c.ampReserved = c.ampCode > 6'h13;
		c.deemphCode = c.halfSwing ? 6'h00 : db + deemphOffset[l];
		c.eqCode = ph2[p][25:22];
		c.sigDetCode = ph2[p][21:20];
		return c;
	endfunction : exp_ctrl

	task automatic chk_lanes();
		for (int l = 0; l < NL; l++) chk(32'(laneCtrl[l]), 32'(exp_ctrl(l)));
	endtask : chk_lanes

	// reset for cyc edges, then every register back to its reset value
	task automatic reset_and_check(input int cyc);
		rst <= 1'b1;
		repeat (cyc) @(negedge clk_sys);
		rst <= 1'b0;
		for (int p = 0; p < NP; p++) begin
			opm[p] = RST_OPMODE;
			ph1[p] = RST_PHY1;
			ph2[p] = RST_PHY2;
		end
		@(negedge clk_sys);
		chk(32'(txElecIdle), 32'(4'hF));
		chk(32'(rxPresent), 32'h0);
		chk(32'(rxDetDone), 32'h0);
		chk_lanes();
		rd_all();
	endtask : reset_and_check

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		reset_and_check(5);
		// every swing and condition combination with random fields
		for (int it = 0; it < 8; it++) begin
			for (int p = 0; p < NP; p++) begin
				// bases under 16 keep totals legal
				wr(p, OFS_OPMODE, $random(seed) & 32'hBDEF_FFFF);
				wr(p, OFS_PHY1, $random(seed));
				wr(p, OFS_PHY2, {1'b0, it[2], 30'($random(seed))});
			end
			gen2Rate <= {NP{it[0]}};
			strongDeemph <= {NP{it[1]}};
			for (int l = 0; l < NL; l++) begin
				ampOffset[l] <= 5'($random(seed)) & 5'h03;
				deemphOffset[l] <= 5'($random(seed));
			end
			@(negedge clk_sys);
			chk_lanes();
			rd_all();
		end
		// top legal base plus one step lands on a reserved code
		wr(0, OFS_OPMODE, 32'h0013_0000);
		wr(0, OFS_PHY2, 32'h0);
		gen2Rate <= '0;
		ampOffset[0] <= 5'h01;
		@(negedge clk_sys);
		chk_lanes();
		// preload and serial write collide on one register
		preloadWr <= '{1'b1, 4'h0, OFS_PHY2, 32'hA5A5_0F0F};
		smbusWr <= '{1'b1, 4'h0, OFS_PHY2, 32'h5A5A_F0F0};
		@(negedge clk_sys);
		preloadWr.en <= 1'b0;
		smbusWr.en <= 1'b0;
		ph2[0] = 32'hA5A5_0F0F;
		rd_all();
		chk_lanes();
		// detect wait for all eight codes
		for (int c = 0; c < 8; c++) begin
			wr(0, OFS_PHY2, 32'(c) << 4);
			farTerm <= NL'($random(seed));
			rxDetStart <= NL'(2'b11);
			@(negedge clk_sys);
			rxDetStart <= '0;
			n = 1;
			while (rxDetDone[0] !== 1'b1 && n < 300) begin
				@(negedge clk_sys);
				n++;
			end
			chk(n, RXDET_US[c] * CPU + 1);
			if (n >= 300) tally_and_finish();
			chk(rxPresent[1:0], farTerm[1:0]);
			@(negedge clk_sys);
			chk(rxDetDone[0], 1'b0);
		end
		// idle latency: zero, fifteen, then random
		for (int k = 0; k < 4; k++) begin
			lat = (k == 0) ? 4'h0 : (k == 1) ? 4'hF : 4'($random(seed));
			wr(0, OFS_PHY2, 32'(lat));
			wr(1, OFS_PHY2, 32'(lat));
			txActive <= NL'(4'b0101);
			repeat (2) @(negedge clk_sys);
			chk(txElecIdle[2], 1'b0);
			txActive <= '0;
			n = 0;
			@(negedge clk_sys);
			while (txElecIdle[2] !== 1'b1 && n < 300) begin
				@(negedge clk_sys);
				n++;
			end
			chk(n, 32'(lat));
			chk(txElecIdle[0], 1'b1);
			if (n >= 300) tally_and_finish();
		end
		// ce low freezes a serial write
		ce <= 1'b0;
		smbusWr <= '{1'b1, 4'h0, OFS_PHY1, 32'h0F0F_A5A5};
		@(negedge clk_sys);
		smbusWr.en <= 1'b0;
		ce <= 1'b1;
		rd_all();
		// second reset in mid-run restores every register
		reset_and_check(2);
		tally_and_finish();
	end
endmodule : test_phy_lane_tuning_control
